//--- design/pbdb_bridge.sv
// Peripheral bus decode bridge: decodes word accesses from the system
// bus into per-unit selects, tags DMA width/burst, maps unit interrupts.
// Assumes all bus and unit inputs come from the same clock domain.
//
// Summary of operation
// (RULE1) Only full word accesses pass to peripherals
// (RULE2) Narrow registers sit right justified in words
// (RULE3) Register width per unit: 32, 16, 8
// (RULE4) DMA burst sizes per unit as listed
// (RULE5) Each engine owns its own 64 Kbyte region
// (RULE6) Base addresses decoded from fixed map
// (RULE7) Bridge decodes programmed access and serves DMA
// (RULE8) Pin controller never raises DMA requests
// (RULE9) Interrupts map to fixed pending bit positions
// (RULE10) Codec and sync engines drive two interrupt lines; the IR port's two engines share one
// (RULE11) General clock engine raises no interrupt
// (RULE12) Pending register shows all unmasked interrupts; the pin controller's unit_irq is not mapped to any bit
// (RULE13) Display controller decoded on system bus directly
// (RULE14) Unmapped accesses select nothing, alter nothing
module pbdb_bridge
    import pbdb_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    input  wire logic                 req_valid,
    input  wire logic                 req_write,
    input  wire logic [31:0]          req_addr,
    input  wire logic [1:0]           req_size,
    input  wire logic [31:0]          req_wdata,
    input  wire logic [NUM_UNITS-1:0] unit_dma_req,
    input  wire logic [NUM_UNITS-1:0] unit_irq,
    input  wire logic [31:0]          irq_mask,
    input  wire logic [31:0]          unit_rdata,
    output logic                      per_sel_valid,
    output logic [NUM_UNITS-1:0]      per_sel,
    output logic                      per_write,
    output logic [15:0]               per_offset,
    output logic [31:0]               per_wdata,
    output logic                      disp_sel,
    output logic                      req_done,
    output logic                      req_error,
    output logic [31:0]               req_rdata,
    output logic [NUM_UNITS-1:0]      dma_req_out,
    output logic [1:0]                dma_width,
    output logic [4:0]                dma_burst,
    output logic [31:0]               irq_pending
);
    // =========================================================
    // Decode helpers
    function automatic logic [NUM_UNITS-1:0] decode(
        input logic [31:0] a);
        logic [NUM_UNITS-1:0]     s;
        logic [UNIT_SEL_BITS-1:0] slot;
        s = '0;
        slot = a[REGION_BITS+UNIT_SEL_BITS-1:REGION_BITS];
        if (a[31:REGION_BITS+UNIT_SEL_BITS]
                == SERIAL_BASE[31:REGION_BITS+UNIT_SEL_BITS]) begin
            s[slot] = 1'b1;                          // [RULE5] [RULE6]
        end
        if (a[31:REGION_BITS] == PIN_BASE[31:REGION_BITS]) begin
            s[U_PIN] = 1'b1;                         // [RULE6]
        end
        if (a[31:REGION_BITS] == DISP_BASE[31:REGION_BITS]) begin
            s[U_DISP] = 1'b1;                        // [RULE13]
        end
        return s;
    endfunction

    function automatic logic [1:0] width_of(input int u);
        case (u)
            U_DISP, U_PIN:   width_of = W32;         // [RULE3]
            U_CODEC, U_SYNC: width_of = W16;         // [RULE3]
            default:         width_of = W8;          // [RULE3]
        endcase
    endfunction

    function automatic logic [4:0] burst_of(input int u);
        case (u)
            U_DISP:                         burst_of = BURST_4W;
            U_USB, U_HSIR, U_CODEC, U_SYNC: burst_of = BURST_8B;
            U_UART1, U_IRUART, U_UART3:     burst_of = BURST_4B;
            default:                        burst_of = BURST_NONE;
        endcase                                      // [RULE4] [RULE8]
    endfunction

    function automatic logic [31:0] mask_width(
        input logic [31:0] d, input logic [1:0] w);
        case (w)
            W8:      mask_width = {24'h000000, d[7:0]};
            W16:     mask_width = {16'h0000, d[15:0]};
            default: mask_width = d;
        endcase                                      // [RULE2]
    endfunction

    logic [NUM_UNITS-1:0] hit;
    logic [NUM_UNITS-1:0] pbus_hit;
    logic                 word_ok;
    logic                 take_ok;
    int                   hit_idx;
    assign hit     = decode(req_addr);
    assign word_ok = (req_size == SIZE_WORD)
                  && (req_addr[ALIGN_BITS-1:0] == WORD_ALIGN);
    assign take_ok = req_valid && word_ok && (hit != '0);

    // Display hits stay on the system bus side
    always_comb begin
        pbus_hit         = hit;
        pbus_hit[U_DISP] = 1'b0;                     // [RULE13]
    end

    always_comb begin
        hit_idx = 0;
        for (int i = 0; i < NUM_UNITS; i++) begin
            if (hit[i]) begin
                hit_idx = i;
            end
        end
    end

    // =========================================================
    // Programmed access: response to the requester
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_done  <= 1'b0;
            req_error <= 1'b0;
        end else if (clk_en) begin
            req_done  <= req_valid;                  // [RULE14]
            req_error <= req_valid && !take_ok;      // [RULE1]
        end
    end

    // Programmed access: selects and write strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            per_sel_valid <= 1'b0;
            per_sel       <= '0;
            per_write     <= 1'b0;
            disp_sel      <= 1'b0;
        end else if (clk_en) begin
            if (take_ok) begin
                per_sel_valid <= ~hit[U_DISP];       // [RULE7]
                per_sel       <= pbus_hit;           // [RULE5]
                disp_sel      <= hit[U_DISP];        // [RULE13]
                per_write     <= req_write;
            end else begin
                per_sel_valid <= 1'b0;               // [RULE14]
                per_sel       <= '0;
                disp_sel      <= 1'b0;
                per_write     <= 1'b0;
            end
        end
    end

    // Offset and write data, held between accepted accesses
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            per_offset <= 16'h0000;
            per_wdata  <= 32'h0000_0000;
        end else if (clk_en && take_ok) begin
            per_offset <= req_addr[REGION_BITS-1:0] & REGION_MASK;
            per_wdata  <= mask_width(req_wdata,
                                     width_of(hit_idx)); // [RULE2]
        end
    end

    // Read data, zero unless a peripheral unit was selected
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            req_rdata <= per_sel_valid ? unit_rdata : 32'h0000_0000;
        end
    end

    // =========================================================
    // DMA request path
    logic [NUM_UNITS-1:0] dma_gate;
    int                   dma_idx;
    always_comb begin
        dma_idx = 0;
        for (int i = NUM_UNITS - 1; i >= 0; i--) begin
            dma_gate[i] = unit_dma_req[i] && (burst_of(i) != BURST_NONE);
            if (dma_gate[i]) begin
                dma_idx = i;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dma_req_out <= '0;
        end else if (clk_en) begin
            dma_req_out <= dma_gate;                 // [RULE7] [RULE8]
        end
    end

    // Width and burst follow the lowest-index unit whose DMA request passes dma_gate
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dma_width <= W8;
            dma_burst <= BURST_NONE;
        end else if (clk_en) begin
            dma_width <= width_of(dma_idx);          // [RULE3]
            dma_burst <= burst_of(dma_idx);          // [RULE4]
        end
    end

    // =========================================================
    // Interrupt pending map
    logic [31:0] raw_irq;
    always_comb begin
        raw_irq            = 32'h0000_0000;
        raw_irq[IRQ_DISP]  = unit_irq[U_DISP];       // [RULE9]
        raw_irq[IRQ_USB]   = unit_irq[U_USB];
        raw_irq[IRQ_UART1] = unit_irq[U_UART1];      // [RULE11]
        raw_irq[IRQ_IR]    = unit_irq[U_IRUART] | unit_irq[U_HSIR];
        raw_irq[IRQ_UART3] = unit_irq[U_UART3];
        raw_irq[IRQ_CODEC] = unit_irq[U_CODEC];      // [RULE10]
        raw_irq[IRQ_SYNC]  = unit_irq[U_SYNC];       // [RULE10]
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_pending <= 32'h0000_0000;
        end else if (clk_en) begin
            irq_pending <= raw_irq & irq_mask;       // [RULE12]
        end
    end
endmodule

//--- design/pbdb_pkg.sv
// Package for the peripheral bus decode bridge: address map, unit
// indices, port widths, burst sizes and interrupt positions.
// Assumes a 32-bit byte-addressed system bus.
package pbdb_pkg;
    // =========================================================
    // Unit indices
    localparam int NUM_UNITS = 10;
    localparam int U_USB     = 0;
    localparam int U_UART1   = 1;
    localparam int U_GCLK    = 2;
    localparam int U_IRUART  = 3;
    localparam int U_HSIR    = 4;
    localparam int U_UART3   = 5;
    localparam int U_CODEC   = 6;
    localparam int U_SYNC    = 7;
    localparam int U_PIN     = 8;
    localparam int U_DISP    = 9;
    // =========================================================
    // Address map
    localparam logic [31:0] SERIAL_BASE  = 32'h8000_0000;
    localparam logic [31:0] PIN_BASE     = 32'h9006_0000;
    localparam logic [31:0] DISP_BASE    = 32'hB010_0000;
    localparam logic [31:0] SERIAL_LAST  = 32'h8007_0000;
    localparam int          REGION_BITS  = 16;
    localparam int          UNIT_SEL_BITS = 3;
    localparam int          ALIGN_BITS   = 2;
    localparam logic [1:0]  WORD_ALIGN   = 2'h0;
    localparam logic [15:0] REGION_MASK  = 16'hFFFF;
    // =========================================================
    // Transfer sizes
    localparam logic [1:0] SIZE_WORD = 2'h2;
    // Register width code: 0 = 8, 1 = 16, 2 = 32 bits
    localparam logic [1:0] W8  = 2'h0;
    localparam logic [1:0] W16 = 2'h1;
    localparam logic [1:0] W32 = 2'h2;
    // Burst length in bytes, zero where no DMA
    localparam logic [4:0] BURST_4W = 5'h10;
    localparam logic [4:0] BURST_8B = 5'h08;
    localparam logic [4:0] BURST_4B = 5'h04;
    localparam logic [4:0] BURST_NONE = 5'h00;
    // =========================================================
    // Interrupt pending positions
    localparam int IRQ_DISP  = 12;
    localparam int IRQ_USB   = 13;
    localparam int IRQ_UART1 = 15;
    localparam int IRQ_IR    = 16;
    localparam int IRQ_UART3 = 17;
    localparam int IRQ_CODEC = 18;
    localparam int IRQ_SYNC  = 19;
endpackage

//--- sim/pbdb_bridge_asserts.sv
// Checker of the bridge ports, bound onto pbdb_bridge.
// Assumes one clock domain; checks pause while clk_en is low.
module pbdb_bridge_asserts
    import pbdb_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 clk_en,
    input wire logic                 req_valid,
    input wire logic [1:0]           req_size,
    input wire logic [NUM_UNITS-1:0] unit_dma_req,
    input wire logic [NUM_UNITS-1:0] unit_irq,
    input wire logic [31:0]          irq_mask,
    input wire logic                 per_sel_valid,
    input wire logic [NUM_UNITS-1:0] per_sel,
    input wire logic                 disp_sel,
    input wire logic                 req_done,
    input wire logic                 req_error,
    input wire logic [NUM_UNITS-1:0] dma_req_out,
    input wire logic [31:0]          irq_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b || !clk_en);
    // ==========================================================
    // Properties
    property p_size; req_valid && req_size != SIZE_WORD |=> req_error;
    endproperty
    property p_nosel; req_error |-> per_sel == '0 && !disp_sel; endproperty
    property p_hot; per_sel_valid |-> $onehot(per_sel); endproperty
    property p_disp; disp_sel |-> !per_sel_valid && req_done; endproperty
    property p_pin; unit_dma_req[U_PIN] |=> !dma_req_out[U_PIN]; endproperty
    property p_irq; (irq_pending & 32'hFFF0_4FFF) == '0; endproperty
    property p_sync; unit_irq[U_SYNC] && irq_mask[IRQ_SYNC]
        |=> irq_pending[IRQ_SYNC]; endproperty
    property p_mask; !irq_mask[IRQ_USB] |=> !irq_pending[IRQ_USB];
    endproperty
    // ==========================================================
    // Assertions
    a_size: assert property (p_size) else $error("size kept");
    a_nosel: assert property (p_nosel) else $error("sel on err");
    a_hot: assert property (p_hot) else $error("sel not one-hot");
    a_disp: assert property (p_disp) else $error("disp on pbus");
    a_pin: assert property (p_pin) else $error("pin dma");
    a_irq: assert property (p_irq) else $error("stray irq bit");
    a_sync: assert property (p_sync) else $error("sync irq lost");
    a_mask: assert property (p_mask) else $error("masked irq");
    c_err: cover property (req_error);
    c_disp: cover property (disp_sel);
    c_two: cover property (irq_pending[IRQ_SYNC] && irq_pending[IRQ_CODEC]);
endmodule

//--- sim/pbdb_unit_model.sv
// Unit model: the selected engine or pin controller answering reads.
// Assumes per_sel is one-hot while per_sel_valid is high.
module pbdb_unit_model
    import pbdb_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 per_sel_valid,
    input  wire logic [NUM_UNITS-1:0] per_sel,
    output logic      [31:0]          unit_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] word;
    logic [31:0] last_reg = 32'h0;
    // ==========================================================
    // Whole word per read; unselected bus shows the inverse of the last
    assign word = 32'hC3C3_0000 | 32'(per_sel);
    assign unit_rdata = per_sel_valid ? word : ~last_reg;
    always @(posedge clk) begin
        if (per_sel_valid) begin
            last_reg <= word;
        end
    end
endmodule

//--- sim/testbench.sv
// Testbench: decode, refusal, DMA and interrupt scenarios.
// Assumes pbdb_pkg, the bridge and the unit model compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pbdb_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, rv = 1'b0, rw = 1'b0;
    logic [1:0] rs = 2'h2, dma_width;
    logic [31:0] ra = 32'h0, wd = 32'h0, mask = 32'h0, urd, pwd, rd, pend;
    logic [NUM_UNITS-1:0] udma = '0, uirq = '0, sel, dmao;
    logic [15:0] ofs;
    logic [4:0] dma_burst;
    logic psv, pw, disp, done, err;
    int n_fail = 0, checks_done = 0, cyc = 0;
    localparam logic [31:0] WM [10] = '{32'hFF, 32'hFF, 32'hFF, 32'hFF,
        32'hFF, 32'hFF, 32'hFFFF, 32'hFFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
    localparam logic [1:0] WC [10] = '{W8, W8, W8, W8, W8, W8, W16, W16,
        W32, W32};
    localparam logic [4:0] BU [10] = '{BURST_8B, BURST_4B, BURST_NONE,
        BURST_4B, BURST_8B, BURST_4B, BURST_8B, BURST_8B, BURST_NONE, BURST_4W};
    localparam int IP [10] = '{13, 15, -1, 16, 16, 17, 18, 19, -1, 12};
    localparam logic [31:0] BAD [4] = '{32'h8000_0000, 32'h8000_0002,
        32'h8008_0000, 32'h9005_0000};
    pbdb_bridge pbdb_bridge_i (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
        .req_valid(rv), .req_write(rw), .req_addr(ra), .req_size(rs),
        .req_wdata(wd), .unit_dma_req(udma), .unit_irq(uirq),
        .irq_mask(mask), .unit_rdata(urd), .per_sel_valid(psv),
        .per_sel(sel), .per_write(pw), .per_offset(ofs), .per_wdata(pwd),
        .disp_sel(disp), .req_done(done), .req_error(err), .req_rdata(rd),
        .dma_req_out(dmao), .dma_width(dma_width), .dma_burst(dma_burst),
        .irq_pending(pend));
    pbdb_unit_model pbdb_unit_model_i (.clk(clk), .per_sel_valid(psv),
        .per_sel(sel), .unit_rdata(urd));
    always #2 clk = ~clk;
    task automatic summarize();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic access(input logic [31:0] a, input logic [1:0] s,
        input logic w);
        @(posedge clk);
        rv <= 1'b1;
        ra <= a;
        rs <= s;
        rw <= w;
        wd <= 32'hFFFF_FFFF;
        @(posedge clk);
        rv <= 1'b0;
        #1;
        check(done, 1'b1);
    endtask
    task automatic settle(input logic [NUM_UNITS-1:0] d,
        input logic [NUM_UNITS-1:0] q, input logic [31:0] m);
        @(posedge clk);
        udma <= d;
        uirq <= q;
        mask <= m;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_decode();
        logic [31:0] a;
        for (int i = 0; i < NUM_UNITS; i++) begin
            a = i < 8 ? 32'h8000_0004 | (i << 16) : 32'h9006_0004;
            a = i == 9 ? 32'hB010_0004 : a;
            access(a, SIZE_WORD, 1'b1);
            check(sel, i < 9 ? 32'h1 << i : 32'h0);
            check(disp, i == 9);
            check(psv, i < 9);
            check(pw, 1'b1);
            check(ofs, 16'h0004);
            check(err, 1'b0);
            if (i < 9) check(pwd, WM[i]);
            access(a, SIZE_WORD, 1'b0);
            check(pw, 1'b0);
            @(posedge clk);
            #1;
            if (i < 9) check(rd, 32'hC3C3_0000 | (32'h1 << i));
            else check(rd, 32'h0);
        end
    endtask
    task automatic t_refuse();
        for (int k = 0; k < 4; k++) begin
            access(BAD[k], k == 0 ? 2'h1 : SIZE_WORD, k > 1);
            check({err, sel}, 32'h400);
            check({psv, disp, pw}, 32'h0);
            @(posedge clk);
            #1;
            check(rd, 32'h0);
        end
    endtask
    task automatic t_dma();
        for (int i = 0; i < NUM_UNITS; i++) begin
            settle(10'h1 << i, '0, 32'h0);
            if (i == U_PIN || i == U_GCLK) begin
                check(dmao, 32'h0);
            end else begin
                check({dma_burst, dma_width, dmao},
                    {BU[i], WC[i], 10'h1 << i});
            end
        end
    endtask
    task automatic t_irq();
        for (int i = 0; i < NUM_UNITS; i++) begin
            settle('0, 10'h1 << i, 32'hFFFF_FFFF);
            if (IP[i] < 0) check(pend, 32'h0);
            else check(pend, 32'h1 << IP[i]);
        end
        settle('0, 10'h0C0, 32'hFFFF_FFFF);
        check(pend, 32'h000C_0000);
        settle('0, 10'h0C0, 32'hFFF7_FFFF);
        check(pend, 32'h0004_0000);
    endtask
    // Clock enable low: a request is never taken, and an interrupt change is held off until clk_en returns
    task automatic t_freeze();
        settle('0, 10'h040, 32'hFFFF_FFFF);
        @(posedge clk);
        clk_en <= 1'b0;
        rv <= 1'b1;
        ra <= 32'h8001_0000;
        rs <= SIZE_WORD;
        rw <= 1'b1;
        uirq <= 10'h001;
        @(posedge clk);
        rv <= 1'b0;
        #1;
        check({done, psv, pw}, 32'h0);
        check(pend, 32'h0004_0000);
        @(posedge clk);
        clk_en <= 1'b1;
        #1;
        check(pend, 32'h0004_0000);
        @(posedge clk);
        #1;
        check(pend, 32'h0000_2000);
    endtask
    // Reset in mid-run clears the pending map until the first live edge
    task automatic t_reset();
        settle('0, 10'h001, 32'hFFFF_FFFF);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        #1;
        check(pend, 32'h0);
        check(dmao, 32'h0);
        @(posedge clk);
        rst_b <= 1'b1;
        #1;
        check(pend, 32'h0);
        @(posedge clk);
        #1;
        check(pend, 32'h0000_2000);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_decode();
        t_refuse();
        t_dma();
        t_irq();
        t_freeze();
        t_reset();
        summarize();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            summarize();
        end
    end
endmodule
bind pbdb_bridge pbdb_bridge_asserts pbdb_bridge_asserts_i (.clk(clk),
    .rst_b(rst_b), .clk_en(clk_en), .req_valid(req_valid),
    .req_size(req_size),
    .unit_dma_req(unit_dma_req), .unit_irq(unit_irq), .irq_mask(irq_mask),
    .per_sel_valid(per_sel_valid), .per_sel(per_sel), .disp_sel(disp_sel),
    .req_done(req_done), .req_error(req_error), .dma_req_out(dma_req_out),
    .irq_pending(irq_pending));
